// *** design/acdc_defines.svh ***
`ifndef ACDC_DEFINES_SVH
`define ACDC_DEFINES_SVH

// ==================================================
// Register indices (byte address is four times the index)
`define ACDC_IDX_SEC_TOP 8'h3B
`define ACDC_IDX_SEC_LOW 8'h3D
`define ACDC_IDX_NM 8'h3E
`define ACDC_IDX_AUTO 8'h40
`define ACDC_IDX_CORE 8'h44
`define ACDC_IDX_PORT 8'h45
`define ACDC_IDX_SRC 8'h46
`define ACDC_IDX_DIV 8'h47
`define ACDC_IDX_CONV 8'h49
`define ACDC_IDX_STATUS 8'h4A

// ==================================================
// Reset values
`define ACDC_RST_SEC_LOW 8'h01
`define ACDC_RST_NM 8'h01
`define ACDC_RST_DIV 8'h01
`define ACDC_RST_ZERO 8'h00

// ==================================================
// Writable bit masks; reserved bits are dropped
`define ACDC_MSK_SEC_TOP 8'h02
`define ACDC_MSK_NM 8'h3F
`define ACDC_MSK_AUTO 8'h01
`define ACDC_MSK_CORE 8'h07
`define ACDC_MSK_PORT 8'h5F
`define ACDC_MSK_SRC 8'h07
`define ACDC_MSK_FULL 8'hFF

// ==================================================
// Field positions
`define ACDC_B_SEC_TOP 1
`define ACDC_B_N_EN 2
`define ACDC_B_M_EN 1
`define ACDC_B_PDM_EN 0
`define ACDC_B_REC_EN 6
`define ACDC_B_PLAY_EN 4
`define ACDC_B_PBCLK_EN 3
`define ACDC_B_SBCLK_EN 2
`define ACDC_B_PFRM_EN 1
`define ACDC_B_SFRM_EN 0
`define ACDC_B_GP_EN 7
`define ACDC_B_AUTO 0

// ==================================================
// Divider code widths and full-range divisors
`define ACDC_W_SEC 9
`define ACDC_W_NM 6
`define ACDC_W_GP 7
`define ACDC_SEC_MAX 10'h200
`define ACDC_NM_MAX 10'h040
`define ACDC_GP_MAX 10'h080
`define ACDC_NSRC 6

`endif

// *** design/acdc_pkg.sv ***
package acdc_pkg;

  // ==================================================
  // Register storage slots
  typedef enum logic [3:0] {
    SL_SEC_LOW = 4'b0000,
    SL_SEC_TOP = 4'b0001,
    SL_NM = 4'b0010,
    SL_CORE = 4'b0011,
    SL_PORT = 4'b0100,
    SL_SRC = 4'b0101,
    SL_DIV = 4'b0110,
    SL_CONV = 4'b0111,
    SL_AUTO = 4'b1000,
    SL_STATUS = 4'b1001,
    SL_NONE = 4'b1111
  } acdc_slot_t;

endpackage

// *** design/acdc_ctrl.sv ***
`include "acdc_defines.svh"

// Behaviour
// - Secondary bit-clock code 0 divides by 512, else by code; resets to 1.
// - With auto detection on, manual secondary and N-M divider values are ignored; the output divider keeps its manual code.
// - Analog N-M six-bit code 0 divides by 64, else by code; resets 1.
// - N, M and PDM enables at bits 2, 1, 0; reset disabled.
// - Record modulator enable bit 6, playback modulator bit 4; reset off.
// - Primary bit-clock enable bit 3, secondary bit 2; reset off.
// - Primary frame enable bit 1, secondary bit 0; reset off.
// - Output source select: PLL, bclk, bclk2, control, osc, DSP; 6-7 none.
// - Output-clock register bit 7 enables the output divider; reset off.
// - Seven-bit output code 0 divides by 128, else by code; resets 1.
// - Top bit of secondary divider comes from a separate register bit 1.
module acdc_ctrl #(
  parameter int unsigned AW = 12
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Divider source strobes, same clock
  input wire logic sec_src_tick,
  input wire logic nm_src_tick,
  input wire logic [`ACDC_NSRC-1:0] gp_src_ticks,
  // Automatically detected divider codes
  input wire logic [`ACDC_W_SEC-1:0] auto_sec_code,
  input wire logic [`ACDC_W_NM-1:0] auto_nm_code,
  // Divided clock strobes
  output logic sec_bitclk_tick,
  output logic nm_tick,
  output logic gp_clock_tick,
  // Divider enables and converter clock setup
  output logic n_divider_enable,
  output logic m_divider_enable,
  output logic pulse_density_divider_enable,
  output logic record_modulator_divider_enable,
  output logic playback_modulator_divider_enable,
  output logic primary_bitclk_divider_enable,
  output logic secondary_bitclk_divider_enable,
  output logic primary_frame_divider_enable,
  output logic secondary_frame_divider_enable,
  output logic [7:0] converter_clock_setup
);

  // ==================================================
  // Parameter check
  if (AW < 10) begin : g_bad_aw
    $error("acdc_ctrl: AW must be at least 10");
  end

  // ==================================================
  // Helpers
  function automatic acdc_pkg::acdc_slot_t slot_of(input logic [7:0] idx);
    unique case (idx)
      `ACDC_IDX_SEC_LOW: slot_of = acdc_pkg::SL_SEC_LOW;
      `ACDC_IDX_SEC_TOP: slot_of = acdc_pkg::SL_SEC_TOP;
      `ACDC_IDX_NM: slot_of = acdc_pkg::SL_NM;
      `ACDC_IDX_CORE: slot_of = acdc_pkg::SL_CORE;
      `ACDC_IDX_PORT: slot_of = acdc_pkg::SL_PORT;
      `ACDC_IDX_SRC: slot_of = acdc_pkg::SL_SRC;
      `ACDC_IDX_DIV: slot_of = acdc_pkg::SL_DIV;
      `ACDC_IDX_CONV: slot_of = acdc_pkg::SL_CONV;
      `ACDC_IDX_AUTO: slot_of = acdc_pkg::SL_AUTO;
      `ACDC_IDX_STATUS: slot_of = acdc_pkg::SL_STATUS;
      default: slot_of = acdc_pkg::SL_NONE;
    endcase
  endfunction

  // Reserved bits never store, so they read back as zero
  function automatic logic [7:0] wmask(input acdc_pkg::acdc_slot_t s);
    unique case (s)
      acdc_pkg::SL_SEC_TOP: wmask = `ACDC_MSK_SEC_TOP;
      acdc_pkg::SL_NM: wmask = `ACDC_MSK_NM;
      acdc_pkg::SL_CORE: wmask = `ACDC_MSK_CORE;
      acdc_pkg::SL_PORT: wmask = `ACDC_MSK_PORT;
      acdc_pkg::SL_SRC: wmask = `ACDC_MSK_SRC;
      acdc_pkg::SL_AUTO: wmask = `ACDC_MSK_AUTO;
      acdc_pkg::SL_SEC_LOW, acdc_pkg::SL_DIV,
      acdc_pkg::SL_CONV: wmask = `ACDC_MSK_FULL;
      default: wmask = `ACDC_RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] rst_val(input int s);
    unique case (s)
      0: rst_val = `ACDC_RST_SEC_LOW;
      2: rst_val = `ACDC_RST_NM;
      6: rst_val = `ACDC_RST_DIV;
      default: rst_val = `ACDC_RST_ZERO;
    endcase
  endfunction

  // Code zero selects the full range of a w-bit field
  function automatic logic [9:0] dec(input logic [9:0] code, input int w);
    dec = (code == 10'h000) ? 10'(32'h0000_0001 << w) : code;
  endfunction

  // ==================================================
  // Declarations
  localparam int NSLOT = 9;
  logic [7:0] regs_r [0:NSLOT-1];
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [31:0] hrdata_r;
  acdc_pkg::acdc_slot_t wr_slot;
  acdc_pkg::acdc_slot_t rd_slot;
  logic addr_ok;
  logic in_range;
  logic auto_en;
  logic [`ACDC_W_SEC-1:0] sec_code;
  logic [`ACDC_W_NM-1:0] nm_code;
  logic [`ACDC_W_GP-1:0] gp_code;
  logic [2:0] gp_sel;
  logic [9:0] div_val [0:2];
  logic [9:0] cnt_r [0:2];
  logic [2:0] en;
  logic [2:0] adv;
  logic [2:0] tick_r;
  logic [7:0] status;
  logic [7:0] rd_val;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ==================================================
  // AHB-Lite bus phases
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign addr_ok = hsel && htrans[1] && hready;
  assign in_range = (haddr[AW-1:10] == '0);
  assign wr_slot = slot_of(wr_idx_r);
  assign rd_slot = in_range ? slot_of(haddr[9:2]) : acdc_pkg::SL_NONE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite && in_range;
      if (addr_ok) begin
        wr_idx_r <= haddr[9:2];
      end
    end
  end

  // ==================================================
  // Register file; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NSLOT; i++) begin
        regs_r[i] <= rst_val(i);
      end
    end else if (wr_pend_r && wr_slot != acdc_pkg::SL_NONE &&
                 wr_slot != acdc_pkg::SL_STATUS) begin
      regs_r[int'(wr_slot)] <= hwdata[7:0] & wmask(wr_slot);
    end
  end

  // Read data is taken in the address phase; a write still in its
  // data phase to the same word is forwarded so no stale value leaks
  assign status = {4'h0, auto_en, en};
  always_comb begin
    rd_val = `ACDC_RST_ZERO;
    if (rd_slot == acdc_pkg::SL_STATUS) begin
      rd_val = status;
    end else if (rd_slot != acdc_pkg::SL_NONE) begin
      if (wr_pend_r && wr_idx_r == haddr[9:2]) begin
        rd_val = hwdata[7:0] & wmask(rd_slot);
      end else begin
        rd_val = regs_r[int'(rd_slot)];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata_r <= {24'h00_0000, rd_val};
    end
  end

  // ==================================================
  // Enables straight from the registers
  assign n_divider_enable = regs_r[3][`ACDC_B_N_EN];
  assign m_divider_enable = regs_r[3][`ACDC_B_M_EN];
  assign pulse_density_divider_enable = regs_r[3][`ACDC_B_PDM_EN];
  assign record_modulator_divider_enable =
    regs_r[4][`ACDC_B_REC_EN];
  assign playback_modulator_divider_enable =
    regs_r[4][`ACDC_B_PLAY_EN];
  assign primary_bitclk_divider_enable =
    regs_r[4][`ACDC_B_PBCLK_EN];
  assign secondary_bitclk_divider_enable =
    regs_r[4][`ACDC_B_SBCLK_EN];
  assign primary_frame_divider_enable =
    regs_r[4][`ACDC_B_PFRM_EN];
  assign secondary_frame_divider_enable =
    regs_r[4][`ACDC_B_SFRM_EN];
  assign converter_clock_setup = regs_r[7];

  // ==================================================
  // Divisor selection
  assign auto_en = regs_r[8][`ACDC_B_AUTO];
  assign sec_code = {regs_r[1][`ACDC_B_SEC_TOP], regs_r[0]};
  assign nm_code = regs_r[2][`ACDC_W_NM-1:0];
  assign gp_code = regs_r[6][`ACDC_W_GP-1:0];
  assign gp_sel = regs_r[5][2:0];

  // Auto codes take over while detection is on
  always_comb begin
    div_val[0] = dec(10'(auto_en ? auto_sec_code : sec_code),
                     `ACDC_W_SEC);
    div_val[1] = dec(10'(auto_en ? auto_nm_code : nm_code),
                     `ACDC_W_NM);
    div_val[2] = dec(10'(gp_code), `ACDC_W_GP);
  end

  // The analog N-M chain needs both of its stages running
  assign en[0] = secondary_bitclk_divider_enable;
  assign en[1] = n_divider_enable && m_divider_enable;
  assign en[2] = regs_r[6][`ACDC_B_GP_EN];

  // Reserved source codes feed no strobes to the divider
  always_comb begin
    adv[0] = sec_src_tick;
    adv[1] = nm_src_tick;
    adv[2] = (gp_sel < 3'(`ACDC_NSRC)) ?
             gp_src_ticks[gp_sel] : 1'b0;
  end

  assign sec_bitclk_tick = tick_r[0];
  assign nm_tick = tick_r[1];
  assign gp_clock_tick = tick_r[2];

  // ==================================================
  // Dividers; one strobe per div_val source strobes
  for (genvar g = 0; g < 3; g++) begin : g_div
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cnt_r[g] <= 10'h000;
        tick_r[g] <= 1'b0;
      end else if (!en[g]) begin
        // Clearing here avoids a runt period when re-enabled
        cnt_r[g] <= 10'h000;
        tick_r[g] <= 1'b0;
      end else if (adv[g]) begin
        if (cnt_r[g] >= div_val[g] - 10'h001) begin
          cnt_r[g] <= 10'h000;
          tick_r[g] <= 1'b1;
        end else begin
          cnt_r[g] <= cnt_r[g] + 10'h001;
          tick_r[g] <= 1'b0;
        end
      end else begin
        tick_r[g] <= 1'b0;
      end
    end

    restart_zero_a: assert property (
      !en[g] |=> (cnt_r[g] == 10'h000) && !tick_r[g])
      else $error("disabled divider did not restart");
  end

  // ==================================================
  // Checks
  sequence wr_to(logic [7:0] idx);
    wr_pend_r && wr_idx_r == idx;
  endsequence

  sec_zero_a: assert property (
    (!auto_en && sec_code == 9'h000) |-> div_val[0] == `ACDC_SEC_MAX)
    else $error("secondary code zero not 512");

  auto_hold_a: assert property (
    (auto_en && $stable(auto_en) && $stable(auto_sec_code)
     && $stable(auto_nm_code)) |-> $stable(div_val[0])
     && $stable(div_val[1]))
    else $error("manual code leaked in auto mode");

  nm_zero_a: assert property (
    (!auto_en && nm_code == 6'h00) |-> div_val[1] == `ACDC_NM_MAX)
    else $error("analog code zero not 64");

  core_en_a: assert property (
    wr_to(`ACDC_IDX_CORE) |=> n_divider_enable == $past(hwdata[2])
    && pulse_density_divider_enable == $past(hwdata[0]))
    else $error("core enable write lost");

  mod_en_a: assert property (
    wr_to(`ACDC_IDX_PORT) |=>
    record_modulator_divider_enable == $past(hwdata[6]) &&
    playback_modulator_divider_enable == $past(hwdata[4]))
    else $error("modulator enable write lost");

  port_en_a: assert property (
    wr_to(`ACDC_IDX_PORT) |=>
    primary_bitclk_divider_enable == $past(hwdata[3]) &&
    secondary_frame_divider_enable == $past(hwdata[0]))
    else $error("port enable write lost");

  gp_src_a: assert property (
    (gp_sel >= 3'h6) |-> !adv[2])
    else $error("reserved source drives divider");

  gp_off_a: assert property (
    !en[2] ##1 !en[2] |-> !gp_clock_tick [*2])
    else $error("output divider ticks while off");

  gp_zero_a: assert property (
    (gp_code == 7'h00) |-> div_val[2] == `ACDC_GP_MAX)
    else $error("output code zero not 128");

  top_bit_a: assert property (
    (!auto_en && regs_r[1][1] && regs_r[0] == 8'h00) |->
    div_val[0] == 10'h100)
    else $error("secondary top bit not applied");

endmodule

// *** tb/audio_clock_divider_ctrl_test.sv ***
`include "acdc_defines.svh"

module audio_clock_divider_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ==================================================
  // Stimulus and observed signals
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hrdy, hresp;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0, hrdata;
  logic sec_t, nm_t, gp_t, s_src = 1'b1, n_src = 1'b1;
  logic [5:0] gp_src = '0, a_nm = '0;
  logic [8:0] a_sec = '0;
  wire [8:0] en;
  logic [7:0] conv;
  int err_count = 0, total_checks = 0, cyc = 0;
  localparam logic [7:0] IX [0:7] = '{`ACDC_IDX_SEC_TOP, `ACDC_IDX_SEC_LOW,
    `ACDC_IDX_NM, `ACDC_IDX_CORE, `ACDC_IDX_PORT, `ACDC_IDX_SRC,
    `ACDC_IDX_DIV, `ACDC_IDX_CONV};
  localparam logic [7:0] RV [0:7] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00,
    8'h00, 8'h01, 8'h00};
  localparam logic [7:0] MK [0:7] = '{8'h02, 8'hFF, 8'h3F, 8'h07, 8'h5F,
    8'h07, 8'hFF, 8'hFF};

  always #4 hclk = ~hclk;

  acdc_ctrl dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
    .sec_src_tick(s_src), .nm_src_tick(n_src), .gp_src_ticks(gp_src),
    .auto_sec_code(a_sec), .auto_nm_code(a_nm), .sec_bitclk_tick(sec_t),
    .nm_tick(nm_t), .gp_clock_tick(gp_t), .n_divider_enable(en[8]),
    .m_divider_enable(en[7]), .pulse_density_divider_enable(en[6]),
    .record_modulator_divider_enable(en[5]),
    .playback_modulator_divider_enable(en[4]),
    .primary_bitclk_divider_enable(en[3]),
    .secondary_bitclk_divider_enable(en[2]),
    .primary_frame_divider_enable(en[1]),
    .secondary_frame_divider_enable(en[0]), .converter_clock_setup(conv)
  );

  // ==================================================
  // Shared tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Address phase held until hready, then the data phase likewise
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
           output logic [31:0] q);
    @(posedge hclk);
    haddr <= {2'b00, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task rc(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, {24'h00_0000, e});
  endtask

  function automatic logic tk(input int w);
    return w == 0 ? sec_t : (w == 1 ? nm_t : gp_t);
  endfunction

  // Ticks are sampled on the falling edge, clear of the launch edge
  task per(input int w, input int e);
    int n;
    n = 0;
    @(negedge hclk);
    while (tk(w) !== 1'b1 && n < 2000) begin
      @(negedge hclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (tk(w) !== 1'b1 && n < 2000);
    chk(32'(n), 32'(e));
  endtask

  task quiet(input int w);
    int c;
    c = 0;
    // A tick launched under the old setting may still stand here
    @(negedge hclk);
    repeat (200) begin
      @(negedge hclk);
      if (tk(w) !== 1'b0) c++;
    end
    chk(32'(c), 32'd0);
  endtask

  // ==================================================
  // Scenarios
  task t_regs;
    for (int i = 0; i < 8; i++) rc(IX[i], RV[i]);
    chk(en, 9'h000);
    chk(hresp, 1'b0);
    for (int i = 0; i < 8; i++) begin
      wr(IX[i], MK[i]);
      rc(IX[i], MK[i]);
    end
    rc(8'h50, 8'h00);
    chk(conv, 8'hFF);
    chk(en, 9'h1FF);
    wr(`ACDC_IDX_PORT, 8'h50);
    wr(`ACDC_IDX_CORE, 8'h05);
    @(negedge hclk);
    chk(en, 9'h170);
    wr(`ACDC_IDX_PORT, 8'h0F);
    @(negedge hclk);
    chk(en, 9'h14F);
    for (int i = 0; i < 8; i++) wr(IX[i], RV[i]);
    $display("register test done");
  endtask

  task t_div;
    wr(`ACDC_IDX_PORT, 8'h04);
    wr(`ACDC_IDX_SEC_LOW, 8'h00);
    per(0, 512);
    wr(`ACDC_IDX_SEC_TOP, 8'h02);
    wr(`ACDC_IDX_SEC_LOW, 8'h03);
    per(0, 259);
    wr(`ACDC_IDX_SEC_TOP, 8'h00);
    wr(`ACDC_IDX_SEC_LOW, 8'h01);
    per(0, 1);
    wr(`ACDC_IDX_CORE, 8'h06);
    wr(`ACDC_IDX_NM, 8'h00);
    per(1, 64);
    wr(`ACDC_IDX_NM, 8'h05);
    per(1, 5);
    // Only the selected source pulses, so a wrong mapping stalls
    for (int s = 0; s < 6; s++) begin
      wr(`ACDC_IDX_SRC, 8'(s));
      gp_src <= 6'h01 << s;
      wr(`ACDC_IDX_DIV, 8'h87);
      per(2, 7);
    end
    wr(`ACDC_IDX_DIV, 8'h80);
    per(2, 128);
    wr(`ACDC_IDX_SRC, 8'h06);
    gp_src <= 6'h3F;
    quiet(2);
    wr(`ACDC_IDX_SRC, 8'h07);
    quiet(2);
    wr(`ACDC_IDX_SRC, 8'h00);
    wr(`ACDC_IDX_DIV, 8'h07);
    quiet(2);
    wr(`ACDC_IDX_PORT, 8'h00);
    quiet(0);
    $display("divider test done");
  endtask

  task t_auto;
    wr(`ACDC_IDX_PORT, 8'h04);
    a_sec <= 9'h005;
    a_nm <= 6'h09;
    wr(`ACDC_IDX_AUTO, 8'h01);
    per(0, 5);
    per(1, 9);
    wr(`ACDC_IDX_AUTO, 8'h00);
    per(1, 5);
    $display("auto detection test done");
  endtask

  // ==================================================
  // Hang guard and main sequence
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      final_report;
    end
  end

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_div;
    t_auto;
    final_report;
  end
endmodule
